// *** design/nand_host_pkg.sv ***
// constants, codes and types shared by the nand host controller
package nand_host_pkg;

	localparam int CLK_NS      = 4;
	localparam int T_SETUP_NS  = 20;
	localparam int T_RP_NS     = 20;
	localparam int T_REA_NS    = 30;
	localparam int T_WHR_NS    = 30;
	localparam int T_WB_NS     = 100;
	localparam int SYNC_STAGES = 2;

	// least times round up to whole clock cycles
	function automatic int ns2cyc(input int ns);
		return (ns + CLK_NS - 1) / CLK_NS;
	endfunction

	localparam int SETUP_CYC = ns2cyc(T_SETUP_NS);
	localparam int WLOW_CYC  = ns2cyc(T_RP_NS);
	localparam int RLOW_CYC  = ns2cyc(T_REA_NS) + SYNC_STAGES;
	localparam int HIGH_CYC  = ns2cyc(T_WHR_NS);
	localparam int WB_CYC    = ns2cyc(T_WB_NS);

	localparam int APB_AW = 8;
	localparam int ADDR_W = 26;
	localparam int OP_W   = 4;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;

	localparam int CTRL_OP_LSB    = 0;
	localparam int CTRL_START_BIT = 8;
	localparam int CTRL_WPOFF_BIT = 9;
	localparam int CTRL_SEL_BIT   = 10;

	localparam int STAT_BUSY      = 0;
	localparam int STAT_RB        = 1;
	localparam int STAT_REFUSED   = 2;
	localparam int STAT_FAIL      = 3;
	localparam int STAT_SBYTE_LSB = 8;
	localparam int STAT_RDATA_LSB = 16;

	localparam int HALF_BIT     = 8;
	localparam int ST_FAIL_BIT  = 0;
	localparam int ST_READY_BIT = 6;

	localparam logic [1:0] ADDR_FIRST_IDX = 2'h0;
	localparam logic [1:0] ERASE_IDX      = 2'h1;
	localparam logic [1:0] ADDR_LAST_IDX  = 2'h3;

	localparam logic [7:0] CMD_READ1       = 8'h00;
	localparam logic [7:0] CMD_READ2       = 8'h01;
	localparam logic [7:0] CMD_READ3       = 8'h50;
	localparam logic [7:0] CMD_SERIAL_IN   = 8'h80;
	localparam logic [7:0] CMD_PROGRAM     = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO    = 8'hd0;
	localparam logic [7:0] CMD_STATUS      = 8'h70;
	localparam logic [7:0] CMD_ID          = 8'h90;
	localparam logic [7:0] CMD_RESET       = 8'hff;
	localparam logic [7:0] ID_ADDR_BYTE    = 8'h00;

	typedef enum logic [3:0] {
		OP_RESET      = 4'h0,
		OP_READ       = 4'h1,
		OP_READ_SPARE = 4'h2,
		OP_RBYTE      = 4'h3,
		OP_PROG_SETUP = 4'h4,
		OP_WBYTE      = 4'h5,
		OP_PROG_GO    = 4'h6,
		OP_ERASE      = 4'h7,
		OP_STATUS     = 4'h8,
		OP_ID         = 4'h9
	} op_t;

	typedef enum logic [1:0] {
		CYC_CMD   = 2'h0,
		CYC_ADDR  = 2'h1,
		CYC_WDATA = 2'h2,
		CYC_RDATA = 2'h3
	} cyc_t;

	// one address byte per cycle, a8 goes out only as the choice of CMD_READ2 over CMD_READ1
	function automatic logic [7:0] addr_byte(input logic [ADDR_W-1:0] a,
		input logic [1:0] i);
		case (i)
			2'h0:    return a[7:0];
			2'h1:    return a[16:9];
			2'h2:    return a[24:17];
			default: return {7'h00, a[25]};
		endcase
	endfunction

endpackage

// *** design/nand_cycle_if.sv ***
// one pin cycle request between the sequencer and the pin driver
`timescale 1ns/1ps
interface nand_cycle_if
	import nand_host_pkg::*;
;
	logic       req;
	cyc_t       kind;
	logic [7:0] wbyte;
	logic       ack;
	logic [7:0] rbyte;

	modport ctl (output req, kind, wbyte, input ack, rbyte);
	modport seq (input req, kind, wbyte, output ack, rbyte);
endinterface

// *** design/nand_pin_seq.sv ***
// strobe timing for one command, address or data cycle on the pins
`timescale 1ns/1ps
module nand_pin_seq
	import nand_host_pkg::*;
#(
	parameter int SETUP_COUNT = SETUP_CYC,
	parameter int WLOW_COUNT  = WLOW_CYC,
	parameter int RLOW_COUNT  = RLOW_CYC,
	parameter int HIGH_COUNT  = HIGH_CYC
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	nand_cycle_if.seq       cif,
	output logic            cle,
	output logic            ale,
	output logic            we_n,
	output logic            read_strobe_n,
	output logic [7:0]      io_out,
	output logic            io_oe_n,
	input  wire logic [7:0] io_in
);
	typedef enum logic [1:0] {
		P_IDLE  = 2'h0,
		P_SETUP = 2'h1,
		P_LOW   = 2'h2,
		P_HIGH  = 2'h3
	} ph_t;

	ph_t        ph_r, ph_nxt;
	cyc_t       kind_r, kind_nxt;
	logic [7:0] cnt_r, cnt_nxt, out_r, out_nxt, rbyte_r, rbyte_nxt;
	logic [7:0] io_meta_r, io_sync_r;
	logic       cle_r, cle_nxt, ale_r, ale_nxt, we_r, we_nxt;
	logic       re_r, re_nxt, oe_r, oe_nxt;

	assign cle           = cle_r;
	assign ale           = ale_r;
	assign we_n          = we_r;
	assign read_strobe_n = re_r;
	assign io_out        = out_r;
	assign io_oe_n       = oe_r;
	assign cif.rbyte     = rbyte_r;
	assign cif.ack       = (ph_r == P_HIGH) && (cnt_r == 8'(HIGH_COUNT-1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_meta_r <= 8'h00;
			io_sync_r <= 8'h00;
		end else begin
			io_meta_r <= io_in;
			io_sync_r <= io_meta_r;
		end
	end

	always_comb begin
		ph_nxt    = ph_r;
		kind_nxt  = kind_r;
		cnt_nxt   = cnt_r + 8'h01;
		out_nxt   = out_r;
		rbyte_nxt = rbyte_r;
		cle_nxt   = cle_r;
		ale_nxt   = ale_r;
		we_nxt    = we_r;
		re_nxt    = re_r;
		oe_nxt    = oe_r;
		case (ph_r)
			P_IDLE: begin
				cnt_nxt = 8'h00;
				if (cif.req) begin
					kind_nxt = cif.kind;
					cle_nxt  = (cif.kind == CYC_CMD);
					ale_nxt  = (cif.kind == CYC_ADDR);
					out_nxt  = cif.wbyte;
					oe_nxt   = (cif.kind == CYC_RDATA);
					ph_nxt   = P_SETUP;
				end
			end
			P_SETUP: begin
				if (cnt_r == 8'(SETUP_COUNT-1)) begin
					cnt_nxt = 8'h00;
					ph_nxt  = P_LOW;
					if (kind_r == CYC_RDATA) begin
						re_nxt = 1'b0;
					end else begin
						we_nxt = 1'b0;
					end
				end
			end
			P_LOW: begin
				if ((kind_r == CYC_RDATA && cnt_r == 8'(RLOW_COUNT-1)) ||
					(kind_r != CYC_RDATA && cnt_r == 8'(WLOW_COUNT-1))) begin
					cnt_nxt = 8'h00;
					ph_nxt  = P_HIGH;
					we_nxt  = 1'b1;
					re_nxt  = 1'b1;
					if (kind_r == CYC_RDATA) begin
						rbyte_nxt = io_sync_r;
					end
				end
			end
			default: begin
				if (cif.ack) begin
					ph_nxt  = P_IDLE;
					cle_nxt = 1'b0;
					ale_nxt = 1'b0;
					oe_nxt  = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_r    <= P_IDLE;
			kind_r  <= CYC_CMD;
			cnt_r   <= 8'h00;
			out_r   <= 8'h00;
			rbyte_r <= 8'h00;
			cle_r   <= 1'b0;
			ale_r   <= 1'b0;
			we_r    <= 1'b1;
			re_r    <= 1'b1;
			oe_r    <= 1'b1;
		end else begin
			ph_r    <= ph_nxt;
			kind_r  <= kind_nxt;
			cnt_r   <= cnt_nxt;
			out_r   <= out_nxt;
			rbyte_r <= rbyte_nxt;
			cle_r   <= cle_nxt;
			ale_r   <= ale_nxt;
			we_r    <= we_nxt;
			re_r    <= re_nxt;
			oe_r    <= oe_nxt;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_strobe_class: assert property (
		!we_r |-> !(cle_r && ale_r) && re_r && !oe_r)
		else $error("write strobe low with bad latch class");
endmodule

// *** design/nand_host.sv ***
// nand host controller: apb registers and operation sequencer
`timescale 1ns/1ps
module nand_host
	import nand_host_pkg::*;
#(
	parameter int WB_COUNT = WB_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   cle,
	output logic                   ale,
	output logic                   ce_n,
	output logic                   we_n,
	output logic                   read_strobe_n,
	output logic                   wp_n,
	output logic      [7:0]        shared_port_byte_out,
	output logic                   shared_port_byte_oe_n,
	input  wire logic [7:0]        shared_port_byte_in,
	input  wire logic              ready_busy_n
);
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_CMD  = 3'h1,
		S_ADDR = 3'h2,
		S_WR   = 3'h3,
		S_RD   = 3'h4,
		S_WB   = 3'h5,
		S_RDY  = 3'h6
	} st_t;

	st_t              st_r, st_nxt;
	op_t              op_r, op_nxt, op_w;
	logic [7:0]       cmd_r, cmd_nxt, cnt_r, cnt_nxt;
	logic [1:0]       idx_r, idx_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [7:0]       wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [7:0]       sbyte_r, sbyte_nxt;
	logic             refused_r, refused_nxt, wp_n_r, wp_n_nxt;
	logic             sel_r, sel_nxt, rb_meta_r, rb_sync_r;
	logic [31:0]      prdata_r, prdata_nxt;
	logic             wr_en, start, refuse, mapped;

	nand_cycle_if cif ();

	nand_pin_seq u_pins (
		.pclk          (pclk),
		.presetn       (presetn),
		.cif           (cif),
		.cle           (cle),
		.ale           (ale),
		.we_n          (we_n),
		.read_strobe_n (read_strobe_n),
		.io_out        (shared_port_byte_out),
		.io_oe_n       (shared_port_byte_oe_n),
		.io_in         (shared_port_byte_in)
	);

	assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_ADDR) ||
		(paddr == OFS_DATA) || (paddr == OFS_STAT);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_r;
	assign ce_n    = !sel_r;
	assign wp_n    = wp_n_r;
	assign wr_en   = psel && penable && pwrite;
	assign start   = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_START_BIT];
	assign op_w    = op_t'(pwdata[CTRL_OP_LSB +: OP_W]);
	assign refuse  = (st_r != S_IDLE) || (op_w > OP_ID) ||
		(!rb_sync_r && op_w != OP_RESET && op_w != OP_STATUS);

	assign cif.req   = (st_r == S_CMD) || (st_r == S_ADDR) ||
		(st_r == S_WR) || (st_r == S_RD);
	assign cif.kind  = (st_r == S_CMD)  ? CYC_CMD  :
		(st_r == S_ADDR) ? CYC_ADDR :
		(st_r == S_WR)   ? CYC_WDATA : CYC_RDATA;
	assign cif.wbyte = (st_r == S_CMD) ? cmd_r :
		(st_r != S_ADDR) ? wdata_r :
		(op_r == OP_ID)  ? ID_ADDR_BYTE : addr_byte(addr_r, idx_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rb_meta_r <= 1'b0;
			rb_sync_r <= 1'b0;
		end else begin
			rb_meta_r <= ready_busy_n;
			rb_sync_r <= rb_meta_r;
		end
	end

	always_comb begin
		if (paddr == OFS_CTRL) begin
			prdata_nxt = 32'h0;
			prdata_nxt[CTRL_OP_LSB +: OP_W] = op_r;
			prdata_nxt[CTRL_WPOFF_BIT] = wp_n_r;
			prdata_nxt[CTRL_SEL_BIT]   = sel_r;
		end else if (paddr == OFS_ADDR) begin
			prdata_nxt = {{(32-ADDR_W){1'b0}}, addr_r};
		end else if (paddr == OFS_DATA) begin
			prdata_nxt = {24'h0, rdata_r};
		end else if (paddr == OFS_STAT) begin
			prdata_nxt = 32'h0;
			prdata_nxt[STAT_BUSY]    = (st_r != S_IDLE);
			prdata_nxt[STAT_RB]      = rb_sync_r;
			prdata_nxt[STAT_REFUSED] = refused_r;
			prdata_nxt[STAT_FAIL] = sbyte_r[ST_FAIL_BIT] &&
				sbyte_r[ST_READY_BIT];
			prdata_nxt[STAT_SBYTE_LSB +: 8] = sbyte_r;
			prdata_nxt[STAT_RDATA_LSB +: 8] = rdata_r;
		end else begin
			prdata_nxt = 32'h0;
		end
		if (!(psel && !penable)) begin
			prdata_nxt = prdata_r;
		end
	end

	always_comb begin
		st_nxt      = st_r;
		op_nxt      = op_r;
		cmd_nxt     = cmd_r;
		idx_nxt     = idx_r;
		cnt_nxt     = cnt_r;
		addr_nxt    = addr_r;
		wdata_nxt   = wdata_r;
		rdata_nxt   = rdata_r;
		sbyte_nxt   = sbyte_r;
		refused_nxt = refused_r;
		wp_n_nxt    = wp_n_r;
		sel_nxt     = sel_r;
		if (wr_en && paddr == OFS_ADDR && st_r == S_IDLE) begin
			addr_nxt = pwdata[ADDR_W-1:0];
		end else if (wr_en && paddr == OFS_DATA && st_r == S_IDLE) begin
			wdata_nxt = pwdata[7:0];
		end else if (wr_en && paddr == OFS_CTRL) begin
			sel_nxt = pwdata[CTRL_SEL_BIT];
			if (st_r == S_IDLE) begin
				wp_n_nxt = pwdata[CTRL_WPOFF_BIT];
			end
		end
		if (start) begin
			refused_nxt = refuse;
			if (!refuse) begin
				op_nxt  = op_w;
				cnt_nxt = 8'h00;
				st_nxt  = S_CMD;
				case (op_w)
					OP_RESET:      cmd_nxt = CMD_RESET;
					OP_READ:       cmd_nxt = addr_r[HALF_BIT] ? CMD_READ2 :
						CMD_READ1;
					OP_READ_SPARE: cmd_nxt = CMD_READ3;
					OP_RBYTE:      st_nxt  = S_RD;
					OP_PROG_SETUP: cmd_nxt = CMD_SERIAL_IN;
					OP_WBYTE:      st_nxt  = S_WR;
					OP_PROG_GO:    cmd_nxt = CMD_PROGRAM;
					OP_ERASE:      cmd_nxt = CMD_ERASE_SETUP;
					OP_STATUS:     cmd_nxt = CMD_STATUS;
					default:       cmd_nxt = CMD_ID;
				endcase
			end
		end
		case (st_r)
			S_CMD: begin
				if (cif.ack) begin
					case (cmd_r)
						CMD_READ1, CMD_READ2, CMD_READ3, CMD_SERIAL_IN: begin
							st_nxt  = S_ADDR;
							idx_nxt = ADDR_FIRST_IDX;
						end
						CMD_ERASE_SETUP: begin
							st_nxt  = S_ADDR;
							idx_nxt = ERASE_IDX;
						end
						CMD_ID: begin
							st_nxt  = S_ADDR;
							idx_nxt = ADDR_LAST_IDX;
						end
						CMD_STATUS: st_nxt = S_RD;
						CMD_PROGRAM, CMD_ERASE_GO, CMD_RESET: st_nxt = S_WB;
						default: st_nxt = S_IDLE;
					endcase
				end
			end
			S_ADDR: begin
				if (cif.ack) begin
					// address cycles up to the fourth
					if (idx_r != ADDR_LAST_IDX) begin
						idx_nxt = idx_r + 2'h1;
					end else if (op_r == OP_ERASE) begin
						st_nxt  = S_CMD;
						cmd_nxt = CMD_ERASE_GO;
					end else if (op_r == OP_READ || op_r == OP_READ_SPARE) begin
						st_nxt = S_WB;
					end else begin
						st_nxt = S_IDLE;
					end
				end
			end
			S_WB: begin
				if (cnt_r == 8'(WB_COUNT-1)) begin
					st_nxt = S_RDY;
				end else begin
					cnt_nxt = cnt_r + 8'h01;
				end
			end
			S_RDY: begin
				if (rb_sync_r) begin
					if (op_r == OP_PROG_GO || op_r == OP_ERASE) begin
						st_nxt  = S_CMD;
						cmd_nxt = CMD_STATUS;
					end else begin
						st_nxt = S_IDLE;
					end
				end
			end
			S_RD: begin
				if (cif.ack) begin
					st_nxt = S_IDLE;
					if (op_r == OP_RBYTE) begin
						rdata_nxt = cif.rbyte;
					end else begin
						sbyte_nxt = cif.rbyte;
					end
				end
			end
			S_WR: begin
				if (cif.ack) begin
					st_nxt = S_IDLE;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= S_IDLE;
			op_r      <= OP_RESET;
			cmd_r     <= CMD_RESET;
			idx_r     <= 2'h0;
			cnt_r     <= 8'h00;
			addr_r    <= '0;
			wdata_r   <= 8'h00;
			rdata_r   <= 8'h00;
			sbyte_r   <= 8'h00;
			refused_r <= 1'b0;
			wp_n_r    <= 1'b0;
			sel_r     <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			st_r      <= st_nxt;
			op_r      <= op_nxt;
			cmd_r     <= cmd_nxt;
			idx_r     <= idx_nxt;
			cnt_r     <= cnt_nxt;
			addr_r    <= addr_nxt;
			wdata_r   <= wdata_nxt;
			rdata_r   <= rdata_nxt;
			sbyte_r   <= sbyte_nxt;
			refused_r <= refused_nxt;
			wp_n_r    <= wp_n_nxt;
			sel_r     <= sel_nxt;
			prdata_r  <= prdata_nxt;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_addr_four_cycles: assert property (
		st_r == S_ADDR && cif.ack && idx_r != ADDR_LAST_IDX |=>
		st_r == S_ADDR && idx_r == $past(idx_r) + 2'h1)
		else $error("address cycle skipped or repeated");
	a_addr_last_byte: assert property (
		st_r == S_ADDR && idx_r == ADDR_LAST_IDX |-> cif.wbyte[7:1] == 7'h0)
		else $error("upper lines not low in fourth address cycle");
	a_wp_steady_busy: assert property (
		st_r != S_IDLE |=> wp_n_r == $past(wp_n_r))
		else $error("write protect moved during operation");
	a_busy_refused: assert property (
		start && !rb_sync_r && op_w != OP_RESET && op_w != OP_STATUS |=>
		refused_r && !($past(st_r) == S_IDLE && st_r != S_IDLE))
		else $error("command issued while device busy");
	a_prog_setup_addr: assert property (
		st_r == S_CMD && cmd_r == CMD_SERIAL_IN && cif.ack |=>
		st_r == S_ADDR && idx_r == ADDR_FIRST_IDX)
		else $error("serial input not followed by address");
	a_erase_confirm: assert property (
		st_r == S_ADDR && cif.ack && idx_r == ADDR_LAST_IDX &&
		op_r == OP_ERASE |=> st_r == S_CMD && cif.wbyte == CMD_ERASE_GO)
		else $error("erase confirm does not follow block address");
	a_fail_gated: assert property (
		psel && !penable && paddr == OFS_STAT |=>
		prdata_r[STAT_FAIL] == ($past(sbyte_r[ST_FAIL_BIT]) &&
		$past(sbyte_r[ST_READY_BIT])))
		else $error("fail reported without ready");
	a_wait_ready: assert property (
		st_r == S_RDY && !rb_sync_r |=> st_r == S_RDY)
		else $error("left ready wait while device busy");

	c_read_page:  cover property (st_r == S_RDY && op_r == OP_READ ##1
		st_r == S_IDLE);
	c_program:    cover property (st_r == S_RD && op_r == OP_PROG_GO &&
		cif.ack);
	c_erase:      cover property (st_r == S_CMD && cmd_r == CMD_ERASE_GO);
	c_refused:    cover property (start && refuse);
endmodule

// *** tb/nand_model.sv ***
// behavioural flash device answering the nand host pins
`timescale 1ns/1ps
module nand_model #(
	parameter logic [7:0] MAKER   = 8'h3c, // arbitrary value
	parameter logic [7:0] DEVICE  = 8'hc3, // arbitrary value
	parameter int         BUSY_NS = 600
) (
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       ce_n,
	input  wire logic       we_n,
	input  wire logic       read_strobe_n,
	input  wire logic       wp_n,
	input  wire logic [7:0] din,
	input  wire logic       fail_next,
	output logic [7:0]      dout,
	output logic            rb_low
);
	logic [7:0]  cmd;
	logic [7:0]  wbuf;
	logic [7:0]  abyte [0:3];
	logic [9:0]  col;
	logic [16:0] page;
	logic        idm;
	logic        stm;
	logic        fail;
	int          na;
	int          gen;

	initial begin
		{cmd, wbuf, col, page, idm, stm, fail} = '0;
		na = 0;
		gen = 0;
		dout = 8'h00;
		rb_low = 1'b0;
	end

	task automatic go();
		gen++;
		rb_low = 1'b1;
		fork
			begin
				automatic int k = gen;
				#BUSY_NS;
				if (k == gen)
					rb_low = 1'b0;
			end
		join_none
	endtask

	task automatic command(input logic [7:0] c);
		case (c)
			8'h00, 8'h01, 8'h50, 8'h80: begin
				na = 0;
				idm = 0;
				stm = 0;
			end
			8'h60: na = 1;
			8'h70: stm = 1;
			8'h90: begin
				idm = 1;
				stm = 0;
				col = 0;
			end
			8'h10, 8'hd0: if (wp_n && cmd == (c == 8'h10 ? 8'h80 : 8'h60)) begin
				fail = fail_next;
				go();
			end
			8'hff: begin
				stm = 0;
				go();
			end
			default: ;
		endcase
		cmd = c;
	endtask

	task automatic address(input logic [7:0] b);
		abyte[na] = b;
		na++;
		if (na == 4 && (cmd == 8'h00 || cmd == 8'h01 || cmd == 8'h50)) begin
			page = {abyte[3][0], abyte[2], abyte[1]};
			col = cmd == 8'h50 ? {6'h20, abyte[0][3:0]}
				: {1'b0, cmd[0], abyte[0]};
			go();
		end
	endtask

	always @(posedge we_n) begin
		if (!ce_n || rb_low) begin
			if (cle && (!rb_low || din == 8'hff || din == 8'h70))
				command(din);
			else if (ale && !rb_low)
				address(din);
			else if (!cle && !rb_low)
				wbuf = din;
		end
	end

	always @(negedge read_strobe_n) begin
		if (!ce_n && !cle && !ale) begin
			if (stm)
				dout = {wp_n, !rb_low, 5'h00, fail};
			else if (idm)
				dout = col == 0 ? MAKER : DEVICE;
			else
				dout = col[7:0] ^ {col[9:8], page[5:0]};
			if (!stm)
				col++;
			if (!stm && !idm && col == 10'd528) begin
				col = cmd == 8'h50 ? 10'd512 : 10'd0;
				page++;
			end
		end
	end

	// released port shows no stale byte
	always @(posedge read_strobe_n)
		dout = ~dout;
endmodule

// *** tb/nand_host_test.sv ***
// self-checking bench for the nand host controller
`timescale 1ns/1ps
module nand_host_test
	import nand_host_pkg::*;
;
	localparam logic [7:0] MAKER  = 8'h3c; // arbitrary value
	localparam logic [7:0] DEVICE = 8'hc3; // arbitrary value
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr, hout, mout, port;
	logic [31:0] pwdata, prdata, q;
	logic        cle, ale, ce_n, we_n, rs_n, wp_n, oe_n, rb_low;
	logic        fail_next, wp;
	int          num_errors, checked;
	int          cyc = 0;

	assign port = oe_n ? mout : hout;

	nand_host #(.WB_COUNT(2)) i_nand_host (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cle(cle),
		.ale(ale), .ce_n(ce_n), .we_n(we_n), .read_strobe_n(rs_n),
		.wp_n(wp_n), .shared_port_byte_out(hout),
		.shared_port_byte_oe_n(oe_n), .shared_port_byte_in(port),
		.ready_busy_n(!rb_low)
	);

	nand_model #(.MAKER(MAKER), .DEVICE(DEVICE)) i_nand_model (
		.cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
		.read_strobe_n(rs_n), .wp_n(wp_n), .din(port),
		.fail_next(fail_next), .dout(mout), .rb_low(rb_low)
	);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [31:0] ctl(input logic [3:0] o, input logic s);
		return (32'h1 << CTRL_SEL_BIT) | ({31'h0, wp} << CTRL_WPOFF_BIT)
			| ({31'h0, s} << CTRL_START_BIT) | {28'h0, o};
	endfunction

	function automatic logic [7:0] ab(input logic [9:0] c,
		input logic [16:0] p);
		return c[7:0] ^ {c[9:8], p[5:0]};
	endfunction

	task automatic wait_idle();
		for (int n = 0; n < 400; n++) begin
			apb(1'b0, OFS_STAT, 32'h0);
			if (q[STAT_BUSY] === 1'b0)
				break;
		end
		chk("idle", 0, q[STAT_BUSY]);
	endtask

	// state leaves idle on the clock edge that takes the start write
	task automatic run(input logic [3:0] o);
		apb(1'b1, OFS_CTRL, ctl(o, 1'b1));
		repeat (2) @(posedge pclk);
		wait_idle();
	endtask

	initial begin
		{presetn, psel, penable, pwrite, fail_next, wp} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		num_errors = 0;
		checked = 0;
		repeat (8) @(posedge pclk);
		chk("reset pins", 6'h2b, {ce_n, wp_n, oe_n, cle, we_n, rs_n});
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		run(OP_ID);
		run(OP_RBYTE);
		chk("maker", MAKER, q[STAT_RDATA_LSB +: 8]);
		run(OP_RBYTE);
		chk("device", DEVICE, q[STAT_RDATA_LSB +: 8]);
		apb(1'b0, OFS_DATA, 32'h0);
		chk("data reg", {24'h0, DEVICE}, q);
		for (int h = 0; h < 2; h++) begin
			apb(1'b1, OFS_ADDR, {6'h00, 17'h15a3c, h[0], 8'h34});
			run(OP_READ);
			chk("read cmd", {7'h00, h[0]}, i_nand_model.cmd);
			for (int k = 0; k < 4; k++)
				chk("addr byte", (32'h015a3c34 >> (8 * k)) & 32'hff,
					i_nand_model.abyte[k]);
			for (int k = 0; k < 2; k++) begin
				run(OP_RBYTE);
				chk("read byte", ab({1'b0, h[0], 8'h34} + 10'(k), 17'h15a3c),
					q[STAT_RDATA_LSB +: 8]);
			end
		end
		apb(1'b1, OFS_ADDR, {6'h00, 17'h00007, 1'b0, 8'h0f});
		run(OP_READ_SPARE);
		run(OP_RBYTE);
		chk("spare", ab(10'd527, 17'h7), q[STAT_RDATA_LSB +: 8]);
		run(OP_RBYTE);
		chk("next page", ab(10'd512, 17'h8), q[STAT_RDATA_LSB +: 8]);
		wp = 1'b1;
		apb(1'b1, OFS_CTRL, ctl(4'h0, 1'b0));
		run(OP_PROG_SETUP);
		apb(1'b1, OFS_DATA, 32'h000000a5);
		run(OP_WBYTE);
		run(OP_PROG_GO);
		chk("prog data", 8'ha5, i_nand_model.wbuf);
		chk("prog status", 8'hc0, q[STAT_SBYTE_LSB +: 8]);
		wp = 1'b0;
		apb(1'b1, OFS_CTRL, ctl(4'h0, 1'b0));
		run(OP_ERASE);
		chk("protected", 8'h40, q[STAT_SBYTE_LSB +: 8]);
		wp = 1'b1;
		fail_next <= 1'b1;
		apb(1'b1, OFS_CTRL, ctl(4'h0, 1'b0));
		run(OP_ERASE);
		chk("erase status", 8'hc1, q[STAT_SBYTE_LSB +: 8]);
		chk("fail flag", 1, q[STAT_FAIL]);
		chk("erase addr", 4, i_nand_model.na);
		fail_next <= 1'b0;
		run(OP_STATUS);
		chk("status", 8'hc1, q[STAT_SBYTE_LSB +: 8]);
		run(OP_RESET);
		chk("reset cmd", 8'hff, i_nand_model.cmd);
		chk("reset taken", 0, q[STAT_REFUSED]);
		apb(1'b1, OFS_CTRL, ctl(OP_PROG_GO, 1'b1));
		apb(1'b1, OFS_CTRL, ctl(OP_STATUS, 1'b1));
		wait_idle();
		chk("busy start", 1, q[STAT_REFUSED]);
		run(4'ha);
		chk("bad op", 1, q[STAT_REFUSED]);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped data", 32'h0, q);
		chk("unmapped err", 1, err);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, OFS_CTRL, ctl(OP_READ, 1'b1));
		apb(1'b0, OFS_STAT, 32'h0);
		chk("early start", 1, q[STAT_REFUSED]);
		chk("early busy", 0, q[STAT_BUSY]);
		run(OP_STATUS);
		chk("late start", 0, q[STAT_REFUSED]);
		close_out();
	end
endmodule
